// file: rtl/fcs_pkg.sv
// Constants, types and register map of the flash command sequencer
package fcs_pkg;
   localparam logic [7:0] FCS_OFF_STATUS = 8'h00;
   localparam logic [7:0] FCS_OFF_INDEX = 8'h04;
   localparam logic [7:0] FCS_OFF_PARAM = 8'h08;
   localparam logic [7:0] FCS_OFF_PROT_STAT = 8'h0C;
   localparam logic [7:0] FCS_OFF_PROT_VAL = 8'h10;
   localparam logic [7:0] FCS_OFF_MARGIN = 8'h14;
   localparam logic [7:0] FCS_OFF_IRQ_STAT = 8'h18;
   localparam logic [7:0] FCS_OFF_IRQ_CLR = 8'h1C;
   localparam logic [7:0] FCS_OFF_IRQ_EN = 8'h20;
   localparam int FCS_ST_CCF = 7;
   localparam int FCS_ST_ACC = 5;
   localparam int FCS_ST_PV = 4;
   localparam int FCS_ST_VE = 1;
   localparam int FCS_ST_VU = 0;
   localparam logic [7:0] FCS_CMD_KEY = 8'h0C;
   localparam logic [7:0] FCS_CMD_MARGIN = 8'h0D;
   localparam logic [7:0] FCS_CMD_ERASE = 8'h12;
   localparam logic [7:0] FCS_CMD_OVRD = 8'h13;
   localparam logic [2:0] FCS_IDX_KEY = 3'h4;
   localparam logic [2:0] FCS_IDX_MARGIN = 3'h2;
   localparam logic [2:0] FCS_IDX_ERASE = 3'h1;
   localparam logic [2:0] FCS_IDX_OVRD = 3'h3;
   localparam logic [1:0] FCS_BDEN_ON = 2'h2;
   localparam logic [15:0] FCS_KEY_INVALID = 16'hFFFF;
   localparam logic [23:0] FCS_KEY0_ADDR = 24'hFF_FE00;
   localparam int FCS_NWORDS = 5;
   localparam int FCS_NIRQ = 3;
   typedef enum logic [1:0] {FCS_IDLE, FCS_EXEC, FCS_ERASE} fcs_state_e;
   typedef struct packed {
      logic acc;
      logic pv;
      logic ve;
      logic vu;
   } fcs_flags_s;
endpackage : fcs_pkg

// file: rtl/fcs_sequencer.sv
// APB command sequencer for flash and EEPROM with interrupt and erase port
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
module fcs_sequencer import fcs_pkg::*; #(
   parameter logic [23:0] EE_BASE = 24'h10_0000,
   parameter logic [23:0] EE_SIZE = 24'h00_0400,
   parameter int SECT_SHIFT = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] backdoor_enable_field,
   input wire logic [63:0] stored_backdoor_key,
   input wire logic [15:0] stored_override_key,
   input wire logic [7:0] base_program_protection,
   input wire logic [7:0] base_eeprom_protection,
   input wire logic erase_mode_ok,
   output logic erase_req,
   output logic [23:0] erase_addr,
   input wire logic erase_done,
   input wire logic erase_verify_err,
   input wire logic erase_verify_uncorr,
   output logic [15:0] margin_level,
   output logic [23:0] margin_addr,
   output logic secure,
   output logic irq
);
   initial begin
      if (SECT_SHIFT < 1 || SECT_SHIFT > 8) $error("SECT_SHIFT out of range");
      if (EE_SIZE == 24'h00_0000) $error("EE_SIZE must not be zero");
   end

   fcs_state_e state_q;
   logic ccf_q;
   fcs_flags_s flags_q;
   logic [2:0] index_q;
   logic [15:0] param_q [FCS_NWORDS];
   logic lockout_q;
   logic secure_q;
   logic ovrd_q;
   logic [7:0] ovrd_prog_q;
   logic [7:0] ovrd_ee_q;
   logic [FCS_NIRQ-1:0] irq_sts_q;
   logic [FCS_NIRQ-1:0] irq_en_q;
   logic [2:0] launch_idx_q;
   logic wr_acc;
   logic rd_acc;
   logic launch;
   logic [7:0] cmd;
   logic [23:0] gaddr;
   logic [23:0] ee_off;
   logic [7:0] sector;
   logic [7:0] ee_prot_eff;
   logic [7:0] prog_prot_eff;
   logic addr_ok;
   logic key_match;
   logic ccf_prev_q;
   logic acc_prev_q;
   logic pv_prev_q;
   logic [31:0] rdata;
   logic mapped;

   // One wait state on every access keeps prdata a plain flop
   assign wr_acc = psel & penable & pwrite & pready;
   assign rd_acc = psel & penable & ~pwrite & ~pready;
   assign launch = wr_acc && paddr == FCS_OFF_STATUS && pwdata[FCS_ST_CCF] && ccf_q;
   assign cmd = param_q[0][15:8];
   assign gaddr = {param_q[0][7:0], param_q[1]};
   assign ee_off = gaddr - EE_BASE;
   assign sector = 8'((ee_off >> SECT_SHIFT));
   assign addr_ok = gaddr >= EE_BASE && ee_off < EE_SIZE;
   assign ee_prot_eff = ovrd_q ? ovrd_ee_q : base_eeprom_protection;
   assign prog_prot_eff = ovrd_q ? ovrd_prog_q : base_program_protection;
   assign key_match = {param_q[1], param_q[2], param_q[3], param_q[4]} == stored_backdoor_key;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
      end
   end

   always_comb begin
      rdata = 32'h0000_0000;
      mapped = 1'b1;
      case (paddr)
         FCS_OFF_STATUS: begin
            rdata[FCS_ST_CCF] = ccf_q;
            rdata[FCS_ST_ACC] = flags_q.acc;
            rdata[FCS_ST_PV] = flags_q.pv;
            rdata[FCS_ST_VE] = flags_q.ve;
            rdata[FCS_ST_VU] = flags_q.vu;
         end
         FCS_OFF_INDEX: rdata[2:0] = index_q;
         FCS_OFF_PARAM: rdata[15:0] = (index_q < 3'(FCS_NWORDS)) ? param_q[index_q] : 16'h0000;
         FCS_OFF_PROT_STAT: rdata[2:0] = {lockout_q, secure_q, ovrd_q};
         FCS_OFF_PROT_VAL: rdata[15:0] = {ee_prot_eff, prog_prot_eff};
         FCS_OFF_MARGIN: rdata[15:0] = margin_level;
         FCS_OFF_IRQ_STAT: rdata[FCS_NIRQ-1:0] = irq_sts_q;
         FCS_OFF_IRQ_CLR: rdata = 32'h0000_0000;
         FCS_OFF_IRQ_EN: rdata[FCS_NIRQ-1:0] = irq_en_q;
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         prdata <= rd_acc ? rdata : 32'h0000_0000;
         pslverr <= psel & penable & ~pready & ~mapped;
      end
   end

   // Parameter words and index frozen while a command runs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         index_q <= 3'h0;
         for (int i = 0; i < FCS_NWORDS; i++) begin
            param_q[i] <= 16'h0000;
         end
      end else if (wr_acc && ccf_q) begin
         if (paddr == FCS_OFF_INDEX) begin
            index_q <= pwdata[2:0];
         end
         if (paddr == FCS_OFF_PARAM && index_q < 3'(FCS_NWORDS)) begin
            param_q[index_q] <= pwdata[15:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= FCS_IDLE;
         ccf_q <= 1'b1;
         flags_q <= '0;
         launch_idx_q <= 3'h0;
         lockout_q <= 1'b0;
         secure_q <= 1'b1;
         ovrd_q <= 1'b0;
         ovrd_prog_q <= 8'h00;
         ovrd_ee_q <= 8'h00;
         erase_req <= 1'b0;
         erase_addr <= 24'h00_0000;
         margin_level <= 16'h0000;
         margin_addr <= 24'h00_0000;
      end else begin
         case (state_q)
            FCS_IDLE: begin
               if (wr_acc && paddr == FCS_OFF_STATUS) begin
                  if (pwdata[FCS_ST_ACC]) flags_q.acc <= 1'b0;
                  if (pwdata[FCS_ST_PV]) flags_q.pv <= 1'b0;
               end
               if (launch) begin
                  ccf_q <= 1'b0;
                  flags_q.ve <= 1'b0;
                  flags_q.vu <= 1'b0;
                  launch_idx_q <= index_q;
                  state_q <= FCS_EXEC;
               end
            end
            FCS_EXEC: begin
               state_q <= FCS_IDLE;
               ccf_q <= 1'b1;
               case (cmd)
                  FCS_CMD_KEY: begin
                     if (launch_idx_q != FCS_IDX_KEY) begin
                        flags_q.acc <= 1'b1;
                     end else if (backdoor_enable_field != FCS_BDEN_ON) begin
                        flags_q.acc <= 1'b1;
                     end else if (lockout_q) begin
                        flags_q.acc <= 1'b1;
                     end else if (key_match) begin
                        secure_q <= 1'b0;
                     end else begin
                        lockout_q <= 1'b1;
                        flags_q.acc <= 1'b1;
                     end
                  end
                  FCS_CMD_MARGIN: begin
                     if (launch_idx_q != FCS_IDX_MARGIN) begin
                        flags_q.acc <= 1'b1;
                     end else begin
                        margin_addr <= gaddr;
                        margin_level <= param_q[2];
                     end
                  end
                  FCS_CMD_ERASE: begin
                     if (launch_idx_q != FCS_IDX_ERASE) begin
                        flags_q.acc <= 1'b1;
                     end else if (!erase_mode_ok || !addr_ok || gaddr[0]) begin
                        flags_q.acc <= 1'b1;
                     end else if (sector < ee_prot_eff) begin
                        flags_q.pv <= 1'b1;
                     end else begin
                        erase_req <= 1'b1;
                        erase_addr <= gaddr;
                        ccf_q <= 1'b0;
                        state_q <= FCS_ERASE;
                     end
                  end
                  FCS_CMD_OVRD: begin
                     if (launch_idx_q != FCS_IDX_OVRD) begin
                        flags_q.acc <= 1'b1;
                     end else if (param_q[1] == FCS_KEY_INVALID) begin
                        ovrd_q <= 1'b0;
                     end else if (param_q[1] != stored_override_key) begin
                        ovrd_q <= 1'b0;
                     end else begin
                        // Unselected side keeps its current effective value
                        ovrd_q <= 1'b1;
                        ovrd_prog_q <= param_q[0][0] ? param_q[2][7:0] : prog_prot_eff;
                        ovrd_ee_q <= param_q[0][1] ? param_q[3][7:0] : ee_prot_eff;
                     end
                  end
                  default: flags_q.acc <= 1'b1;
               endcase
            end
            FCS_ERASE: begin
               // The array pulses done for one cycle; only request is a level
               if (erase_done) begin
                  erase_req <= 1'b0;
                  flags_q.ve <= erase_verify_err;
                  flags_q.vu <= erase_verify_uncorr;
                  ccf_q <= 1'b1;
                  state_q <= FCS_IDLE;
               end
            end
            default: state_q <= FCS_IDLE;
         endcase
      end
   end

   assign secure = secure_q;

   // Set wins over a clear written in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_sts_q <= '0;
         irq_en_q <= '0;
         irq <= 1'b0;
      end else begin
         if (wr_acc && paddr == FCS_OFF_IRQ_EN) begin
            irq_en_q <= pwdata[FCS_NIRQ-1:0];
         end
         irq_sts_q <= (irq_sts_q & ~((wr_acc && paddr == FCS_OFF_IRQ_CLR)
                       ? pwdata[FCS_NIRQ-1:0] : {FCS_NIRQ{1'b0}}))
                      | {1'b0, 1'b0, ccf_q & ~ccf_prev_q}
                      | {flags_q.pv & ~pv_prev_q, flags_q.acc & ~acc_prev_q, 1'b0};
         irq <= |(irq_sts_q & irq_en_q);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ccf_prev_q <= 1'b1;
         acc_prev_q <= 1'b0;
         pv_prev_q <= 1'b0;
      end else begin
         ccf_prev_q <= ccf_q;
         acc_prev_q <= flags_q.acc;
         pv_prev_q <= flags_q.pv;
      end
   end

   chk_lock_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      lockout_q |=> lockout_q) else $error("lockout cleared without reset");
   chk_key_disabled: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == FCS_EXEC && cmd == FCS_CMD_KEY && backdoor_enable_field != FCS_BDEN_ON
      |=> flags_q.acc && secure_q == $past(secure_q)) else $error("key check not refused");
   chk_key_release: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == FCS_EXEC && cmd == FCS_CMD_KEY && launch_idx_q == FCS_IDX_KEY
      && backdoor_enable_field == FCS_BDEN_ON && !lockout_q && key_match
      |=> !secure_q) else $error("matching key did not release");
   chk_key_done: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == FCS_EXEC && cmd == FCS_CMD_KEY |=> ccf_q) else $error("key check not done");
   chk_key_index: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == FCS_EXEC && cmd == FCS_CMD_KEY && launch_idx_q != FCS_IDX_KEY
      |=> flags_q.acc && $stable(secure_q)) else $error("bad index accepted");
   chk_erase_odd: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == FCS_EXEC && cmd == FCS_CMD_ERASE && gaddr[0]
      |=> flags_q.acc && !erase_req) else $error("odd erase address accepted");
   chk_erase_index: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == FCS_EXEC && cmd == FCS_CMD_ERASE && launch_idx_q != FCS_IDX_ERASE
      |=> flags_q.acc && !erase_req) else $error("erase index accepted");
   chk_erase_prot: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(flags_q.pv) |-> !erase_req) else $error("protected sector erased");
   chk_erase_pv: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == FCS_EXEC && cmd == FCS_CMD_ERASE && launch_idx_q == FCS_IDX_ERASE
      && erase_mode_ok && addr_ok && !gaddr[0] && sector < ee_prot_eff
      |=> flags_q.pv && !erase_req) else $error("protected erase not refused");
   chk_erase_go: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == FCS_EXEC && cmd == FCS_CMD_ERASE && launch_idx_q == FCS_IDX_ERASE
      && erase_mode_ok && addr_ok && !gaddr[0] && sector >= ee_prot_eff
      |=> erase_req && erase_addr == $past(gaddr)) else $error("valid erase not started");
   chk_erase_ccf: assert property (@(posedge pclk) disable iff (!presetn)
      erase_req |-> !ccf_q) else $error("complete during erase");
   chk_verify_copy: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == FCS_ERASE && erase_done
      |=> flags_q.ve == $past(erase_verify_err) && flags_q.vu == $past(erase_verify_uncorr)
      && ccf_q) else $error("verify status lost");
   chk_ovrd_bad: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == FCS_EXEC && cmd == FCS_CMD_OVRD && launch_idx_q == FCS_IDX_OVRD
      && param_q[1] != stored_override_key |=> !ovrd_q) else $error("override kept");
   chk_ovrd_ffff: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == FCS_EXEC && cmd == FCS_CMD_OVRD && launch_idx_q == FCS_IDX_OVRD
      && param_q[1] == FCS_KEY_INVALID |=> !ovrd_q) else $error("invalid key enabled override");
   chk_ovrd_set: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == FCS_EXEC && cmd == FCS_CMD_OVRD && launch_idx_q == FCS_IDX_OVRD
      && param_q[1] != FCS_KEY_INVALID && param_q[1] == stored_override_key
      |=> ovrd_q) else $error("override not applied");
   chk_param_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !ccf_q |=> $stable(index_q) && $stable(param_q[0])) else $error("params changed");
   chk_margin_set: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == FCS_EXEC && cmd == FCS_CMD_MARGIN && launch_idx_q == FCS_IDX_MARGIN
      |=> margin_level == $past(param_q[2])) else $error("margin not set");
endmodule : fcs_sequencer

// file: bench/fcs_array_model.sv
// Behavioural EEPROM array that answers erase requests after a set latency
`timescale 1ns/1ps
module fcs_array_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic erase_req,
   input wire logic [7:0] lat,
   input wire logic inj_err,
   input wire logic inj_uncorr,
   output logic erase_done,
   output logic erase_verify_err,
   output logic erase_verify_uncorr
);
   logic [7:0] cnt_q;
   logic tog_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 8'h00;
         erase_done <= 1'b0;
         tog_q <= 1'b0;
      end else begin
         tog_q <= ~tog_q;
         if (erase_done || !erase_req) begin
            erase_done <= 1'b0;
            cnt_q <= 8'h00;
         end else if (cnt_q == lat) begin
            erase_done <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 8'h01;
         end
      end
   end
   // Verify lines are only meaningful with done, so they wander otherwise
   assign erase_verify_err = erase_done ? inj_err : tog_q;
   assign erase_verify_uncorr = erase_done ? inj_uncorr : ~tog_q;
endmodule : fcs_array_model

// file: bench/testbench.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
module testbench;
   import fcs_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, serr, erase_req, erase_done, ve_in, vu_in, secure, irq;
   logic [1:0] bd_en = 2'h2;
   logic [63:0] bkey = 64'h0000_0000_0000_0000;
   logic [15:0] okey = 16'h0000, margin_level;
   logic [7:0] pprot = 8'h00, eprot = 8'h00, lat = 8'h0a;
   logic mode_ok = 1, inj_e = 0, inj_u = 0;
   logic [23:0] erase_addr, margin_addr, addr;
   logic [15:0] wd [5];
   int err_count = 0, tests_run = 0, i, nreq = 0, n0;
   always #5 pclk = ~pclk;
   always @(posedge erase_req) nreq++;
   fcs_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .backdoor_enable_field(bd_en), .stored_backdoor_key(bkey),
      .stored_override_key(okey), .base_program_protection(pprot),
      .base_eeprom_protection(eprot), .erase_mode_ok(mode_ok), .erase_req(erase_req),
      .erase_addr(erase_addr), .erase_done(erase_done), .erase_verify_err(ve_in),
      .erase_verify_uncorr(vu_in), .margin_level(margin_level), .margin_addr(margin_addr),
      .secure(secure), .irq(irq));
   fcs_array_model i_arr (.pclk(pclk), .presetn(presetn), .erase_req(erase_req), .lat(lat),
      .inj_err(inj_e), .inj_uncorr(inj_u), .erase_done(erase_done),
      .erase_verify_err(ve_in), .erase_verify_uncorr(vu_in));
   task automatic final_report;
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   function automatic logic [31:0] exp_st(input logic acc, pv, ve, vu);
      return {24'h00_0000, 1'b1, 1'b0, acc, pv, 2'b00, ve, vu};
   endfunction : exp_st
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_count++;
         final_report();
      end
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic cmd(input int n, input logic [2:0] idx);
      int k;
      apb(1, FCS_OFF_STATUS, 32'h0000_0030);
      for (k = 0; k < n; k++) begin
         apb(1, FCS_OFF_INDEX, 32'(k));
         apb(1, FCS_OFF_PARAM, {16'h0000, wd[k]});
      end
      apb(1, FCS_OFF_INDEX, {29'h0, idx});
      apb(1, FCS_OFF_STATUS, 32'h0000_0080);
      // Index change while busy must be ignored
      apb(1, FCS_OFF_INDEX, 32'h0000_0000);
      k = 0;
      do begin
         apb(0, FCS_OFF_STATUS, 32'h0);
         k++;
      end while (rd[7] !== 1'b1 && k < 60);
      if (k >= 60) begin
         err_count++;
         final_report();
      end
      rd = rd & 32'h0000_00b3;
   endtask : cmd
   task automatic key_cmd(input logic [63:0] k, input logic [2:0] idx);
      wd[0] = {FCS_CMD_KEY, 8'h00};
      wd[1] = k[63:48];
      wd[2] = k[47:32];
      wd[3] = k[31:16];
      wd[4] = k[15:0];
      cmd(5, idx);
   endtask : key_cmd
   task automatic do_reset;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
   endtask : do_reset
   initial begin
      rd = $urandom(32'hdd9942d9);
      bkey = {$urandom, $urandom};
      okey = 16'($urandom_range(0, 16'h7fff));
      do_reset();
      apb(0, FCS_OFF_STATUS, 32'h0);
      chk("reset status", rd & 32'h0000_00b3, exp_st(0, 0, 0, 0));
      apb(0, FCS_OFF_PROT_STAT, 32'h0);
      chk("reset prot stat", rd & 32'h7, 32'h2);
      apb(0, 8'hfc, 32'h0);
      chk("unmapped err", serr, 1);
      for (i = 0; i < 4; i++) begin
         bd_en <= (i == 2) ? 2'h3 : 2'(i);
         key_cmd(bkey, FCS_IDX_KEY);
         chk("backdoor_enable_field off", rd, exp_st(1, 0, 0, 0));
      end
      bd_en <= FCS_BDEN_ON;
      key_cmd(bkey, 3'h3);
      chk("key index", rd, exp_st(1, 0, 0, 0));
      key_cmd(bkey, FCS_IDX_KEY);
      chk("key ok", rd, exp_st(0, 0, 0, 0));
      chk("released", secure, 0);
      do_reset();
      chk("secure reset", secure, 1);
      key_cmd(bkey ^ (64'h1 << $urandom_range(0, 63)), FCS_IDX_KEY);
      chk("key bad", rd, exp_st(1, 0, 0, 0));
      key_cmd(bkey, FCS_IDX_KEY);
      chk("lockout", rd, exp_st(1, 0, 0, 0));
      apb(0, FCS_OFF_PROT_STAT, 32'h0);
      chk("lock stat", rd & 32'h7, 32'h6);
      addr = 24'($urandom);
      wd[0] = {FCS_CMD_MARGIN, addr[23:16]};
      wd[1] = addr[15:0];
      wd[2] = 16'($urandom);
      cmd(3, FCS_IDX_MARGIN);
      chk("margin lvl", margin_level, wd[2]);
      chk("margin addr", margin_addr, addr);
      apb(0, FCS_OFF_MARGIN, 32'h0);
      chk("margin reg", rd[15:0], wd[2]);
      for (i = 0; i < 9; i++) begin
         // Cases 0..3 random good erases, then odd, range, mode, index, protected
         addr = 24'h10_0000 | {14'h0, 9'($urandom), 1'b0};
         inj_e <= 1'($urandom);
         inj_u <= 1'($urandom);
         lat <= 8'($urandom_range(10, 30));
         if (i == 4) addr[0] = 1'b1;
         if (i == 5) addr = 24'h20_0000;
         mode_ok <= (i != 6);
         eprot <= (i == 8) ? 8'hff : 8'h00;
         if (i == 8) addr[9:8] = 2'b00;
         wd[0] = {FCS_CMD_ERASE, addr[23:16]};
         wd[1] = addr[15:0];
         n0 = nreq;
         cmd(2, (i == 7) ? 3'h2 : FCS_IDX_ERASE);
         if (i < 4) begin
            chk("erase st", rd, exp_st(0, 0, inj_e, inj_u));
            chk("erase addr", erase_addr[23:2], addr[23:2]);
            chk("erase req", 32'(nreq - n0), 1);
            apb(0, FCS_OFF_INDEX, 32'h0);
            chk("busy index", rd[2:0], FCS_IDX_ERASE);
         end else begin
            chk("erase bad", rd, exp_st(i < 8, i == 8, 0, 0));
            chk("no erase", 32'(nreq - n0), 0);
         end
      end
      mode_ok <= 1'b1;
      for (i = 0; i < 4; i++) begin
         wd[0] = {FCS_CMD_OVRD, 8'h03};
         wd[1] = (i == 1) ? FCS_KEY_INVALID : (i == 3) ? okey ^ 16'h0001 : okey;
         wd[2] = 16'($urandom_range(0, 255));
         wd[3] = 16'($urandom_range(0, 255));
         cmd(4, FCS_IDX_OVRD);
         apb(0, FCS_OFF_PROT_STAT, 32'h0);
         chk("ovrd active", rd[0], i[0] == 0);
         apb(0, FCS_OFF_PROT_VAL, 32'h0);
         if (i == 2) chk("ovrd values", rd[15:0], {wd[3][7:0], wd[2][7:0]});
      end
      apb(1, FCS_OFF_IRQ_EN, 32'h0);
      apb(1, FCS_OFF_IRQ_CLR, 32'h7);
      wd[0] = {FCS_CMD_MARGIN, 8'h00};
      cmd(1, 3'h1);
      apb(0, FCS_OFF_IRQ_STAT, 32'h0);
      chk("irq stat", rd[2:0], 3'b011);
      chk("irq masked", irq, 0);
      apb(1, FCS_OFF_IRQ_EN, 32'h2);
      apb(0, FCS_OFF_STATUS, 32'h0);
      chk("irq on", irq, 1);
      apb(1, FCS_OFF_IRQ_CLR, 32'h7);
      apb(0, FCS_OFF_IRQ_STAT, 32'h0);
      chk("irq cleared", rd[2:0], 3'b000);
      chk("irq off", irq, 0);
      final_report();
   end
endmodule : testbench
